// ---- core/autoseq_consts.vh ----
`ifndef AUTOSEQ_CONSTS_VH
`define AUTOSEQ_CONSTS_VH
// sequence geometry
`define MAX_TESTS      4'd8
`define SLOT_W         4
`define CNT_W          16
`define CNT_MAX        16'hFFFF
`define CNT_ZERO       16'h0000
// status codes per test
`define ST_IDLE        3'h0
`define ST_RUN         3'h1
`define ST_PASS        3'h2
`define ST_FAIL        3'h3
`define ST_DONE        3'h4
`define ST_HALT        3'h5
// compare condition encoding
`define COND_DIFF      1'b0
`define COND_MATCH     1'b1
// continuous compare mode encoding
`define MODE_HALT_IF   1'b0
`define MODE_COUNT_IF  1'b1
// display view select
`define VIEW_SETUP     1'b0
`define VIEW_RESULTS   1'b1
`endif

// ---- core/test_counters.v ----
`timescale 1ns/10ps
`include "autoseq_consts.vh"
module test_counters (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // control
   input  wire        clear,
   input  wire        bump,
   input  wire        passed,
   // counts
   output reg  [15:0] pass_q,
   output reg  [15:0] fail_q,
   output reg  [15:0] att_q
);
   // plain increment wraps 65535 to zero by width alone
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         pass_q <= `CNT_ZERO;
         fail_q <= `CNT_ZERO;
         att_q  <= `CNT_ZERO;
      end
      else if (clear)
      begin
         pass_q <= `CNT_ZERO;
         fail_q <= `CNT_ZERO;
         att_q  <= `CNT_ZERO;
      end
      else if (bump)
      begin
         att_q <= att_q + 16'h0001; // RULE_01
         if (passed)
            pass_q <= pass_q + 16'h0001; // RULE_01
         else
            fail_q <= fail_q + 16'h0001; // RULE_01
      end
endmodule // test_counters

// ---- core/compare_autosequencer.v ----
// How it works
// RULE_01 - counters wrap from 65535 to zero
// RULE_02 - up to eight independent tests per sequence
// RULE_03 - passes-to-run accepts 0 through 65535
// RULE_04 - operator keeps setups in consecutive slots
// RULE_05 - read setup, load its reference file
// RULE_06 - capture, compare, update, advance to next setup
// RULE_07 - test stops after its passes-to-run
// RULE_08 - test identified by its setup file number
// RULE_09 - separate counts per test, updated each compare
// RULE_10 - status: run, pass, fail, done, halt
// RULE_11 - halt-if condition met stops whole sequence
// RULE_12 - abort command stops sequence immediately
// RULE_13 - start begins at start file, results view
// RULE_14 - setup compare parameters applied per test
// RULE_15 - halt on condition, pass by pass condition
// RULE_16 - condition 0 means difference, 1 match
// RULE_17 - wrap past end, skip finished, then conclude
`timescale 1ns/10ps
`include "autoseq_consts.vh"
module compare_autosequencer (
   // clock and reset
   input  wire         clk,
   input  wire         rst,
   // operator commands and range
   input  wire         begin_sequence_key,
   input  wire         abort_key,
   input  wire [3:0]   start_file,
   input  wire [3:0]   end_file,
   // setup store read port
   output reg          setup_rd_q,
   output reg  [3:0]   setup_slot_q,
   input  wire         setup_valid,
   input  wire [3:0]   setup_ref_file,
   input  wire [15:0]  setup_passes,
   input  wire [15:0]  setup_a_start,
   input  wire [15:0]  setup_b_start,
   input  wire [15:0]  setup_b_end,
   input  wire         setup_word_mode,
   input  wire [3:0]   setup_skew,
   input  wire         setup_cond,
   input  wire         setup_cont_mode,
   input  wire         setup_pass_cond,
   // reference memory load
   output reg          ref_load_q,
   output reg  [3:0]   ref_file_q,
   input  wire         ref_done,
   // capture
   output reg          capture_q,
   input  wire         capture_done,
   // compare engine
   output reg          compare_q,
   output reg  [15:0]  cmp_a_start_q,
   output reg  [15:0]  cmp_b_start_q,
   output reg  [15:0]  cmp_b_end_q,
   output reg          cmp_word_mode_q,
   output reg  [3:0]   cmp_skew_q,
   output reg          cmp_cond_q,
   input  wire         compare_done,
   input  wire [15:0]  compare_hits,
   // results
   output reg          active_q,
   output reg          view_q,
   output reg          refresh_q,
   output wire [23:0]  status_flat,
   output wire [127:0] pass_flat,
   output wire [127:0] fail_flat,
   output wire [127:0] att_flat,
   output reg  [3:0]   cur_test_q
);
   ////////////////////////////////////////////////////////////////////////
   localparam [6:0] S_IDLE = 7'h01, S_SETUP = 7'h02, S_REF = 7'h04, S_CAP = 7'h08,
                    S_CMP  = 7'h10, S_UPD   = 7'h20, S_NEXT = 7'h40;
   reg  [6:0]  state_q;
   reg  [2:0]  idx_q;
   reg  [2:0]  last_q;
   reg  [3:0]  base_q;
   reg  [15:0] goal_q;
   reg  [2:0]  status_q [0:7];
   reg  [15:0] goal_mem_q [0:7];
   reg  [7:0]  fin_q;
   reg         mode_q;
   reg         pcond_q;
   reg         cnt_clear_q;
   wire [15:0] pass_c [0:7];
   wire [15:0] att_c  [0:7];

   // condition met: hits present for the chosen condition, whichever it is
   function cond_met;
      input [15:0] hits;
      begin
         cond_met = (hits != `CNT_ZERO);
      end
   endfunction

   wire met      = cond_met(compare_hits);
   // pass judged on pass condition: met when it equals the halt condition, else not met
   wire pass_now = (pcond_q == cmp_cond_q) ? met : !met; // RULE_15 RULE_16
   wire halt_now = (mode_q == `MODE_HALT_IF) && met; // RULE_11 RULE_15
   // counts stop at the goal; a zero goal is finished at once
   wire reached  = (att_c[idx_q] + 16'h0001) == goal_q; // RULE_07

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : per_test
         test_counters u_cnt (
            .clk    (clk),
            .rst    (rst),
            .clear  (cnt_clear_q),
            .bump   (state_q == S_UPD && idx_q == g),
            .passed (pass_now),
            .pass_q (pass_c[g]),
            .fail_q (fail_flat[g*16 +: 16]),
            .att_q  (att_c[g])
         ); // RULE_09
         assign pass_flat[g*16 +: 16] = pass_c[g];
         assign att_flat[g*16 +: 16]  = att_c[g];
         assign status_flat[g*3 +: 3] = status_q[g]; // RULE_10
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // next unfinished index after idx_q, wrapping at last_q
   reg [2:0] nxt;
   reg       any_left;
   integer   k;
   always @*
   begin
      nxt = idx_q;
      any_left = 1'b0;
      for (k = 8; k >= 1; k = k - 1)
         if (((idx_q + k[2:0]) & 3'h7) <= last_q && !fin_q[(idx_q + k[2:0]) & 3'h7])
         begin
            nxt = (idx_q + k[2:0]) & 3'h7;
            any_left = 1'b1;
         end
   end

   ////////////////////////////////////////////////////////////////////////
   integer i;
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         state_q <= S_IDLE;
         idx_q <= 3'h0;
         last_q <= 3'h0;
         base_q <= 4'h0;
         goal_q <= `CNT_ZERO;
         fin_q <= 8'h00;
         mode_q <= 1'b0;
         pcond_q <= 1'b0;
         cnt_clear_q <= 1'b0;
         setup_rd_q <= 1'b0;
         setup_slot_q <= 4'h0;
         ref_load_q <= 1'b0;
         ref_file_q <= 4'h0;
         capture_q <= 1'b0;
         compare_q <= 1'b0;
         cmp_a_start_q <= `CNT_ZERO;
         cmp_b_start_q <= `CNT_ZERO;
         cmp_b_end_q <= `CNT_ZERO;
         cmp_word_mode_q <= 1'b0;
         cmp_skew_q <= 4'h0;
         cmp_cond_q <= 1'b0;
         active_q <= 1'b0;
         view_q <= `VIEW_SETUP;
         refresh_q <= 1'b0;
         cur_test_q <= 4'h0;
         for (i = 0; i < 8; i = i + 1)
         begin
            status_q[i] <= `ST_IDLE;
            goal_mem_q[i] <= `CNT_ZERO;
         end
      end
      else
      begin
         setup_rd_q <= 1'b0;
         ref_load_q <= 1'b0;
         capture_q <= 1'b0;
         compare_q <= 1'b0;
         refresh_q <= 1'b0;
         cnt_clear_q <= 1'b0;
         if (abort_key && state_q != S_IDLE)
         begin
            state_q <= S_IDLE; // RULE_12
            active_q <= 1'b0;
         end
         else
            case (state_q)
               S_IDLE:
                  if (begin_sequence_key)
                  begin
                     // operator guarantees a consecutive slot range
                     idx_q <= 3'h0; // RULE_13 RULE_04
                     last_q <= (end_file - start_file > 4'd7) ? 3'h7
                              : end_file[2:0] - start_file[2:0]; // RULE_02
                     fin_q <= 8'h00;
                     cnt_clear_q <= 1'b1;
                     active_q <= 1'b1;
                     view_q <= `VIEW_RESULTS; // RULE_13
                     refresh_q <= 1'b1;
                     setup_slot_q <= start_file; // RULE_13
                     base_q <= start_file; // range held so key edits mid-run cannot shift slots
                     setup_rd_q <= 1'b1;
                     cur_test_q <= start_file; // RULE_08
                     state_q <= S_SETUP;
                     for (i = 0; i < 8; i = i + 1)
                        status_q[i] <= `ST_IDLE;
                  end
               S_SETUP:
                  if (setup_valid)
                  begin
                     goal_q <= setup_passes; // RULE_03
                     goal_mem_q[idx_q] <= setup_passes;
                     cmp_a_start_q <= setup_a_start; // RULE_14
                     cmp_b_start_q <= setup_b_start;
                     cmp_b_end_q <= setup_b_end;
                     cmp_word_mode_q <= setup_word_mode;
                     cmp_skew_q <= setup_skew;
                     cmp_cond_q <= setup_cond;
                     mode_q <= setup_cont_mode;
                     pcond_q <= setup_pass_cond;
                     if (setup_passes == `CNT_ZERO)
                     begin
                        fin_q[idx_q] <= 1'b1; // RULE_07
                        status_q[idx_q] <= `ST_DONE;
                        state_q <= S_NEXT;
                     end
                     else
                     begin
                        ref_file_q <= setup_ref_file; // RULE_05
                        ref_load_q <= 1'b1;
                        status_q[idx_q] <= `ST_RUN; // RULE_10
                        refresh_q <= 1'b1;
                        state_q <= S_REF;
                     end
                  end
               S_REF:
                  if (ref_done)
                  begin
                     capture_q <= 1'b1; // RULE_06
                     state_q <= S_CAP;
                  end
               S_CAP:
                  if (capture_done)
                  begin
                     compare_q <= 1'b1; // RULE_06
                     state_q <= S_CMP;
                  end
               S_CMP:
                  if (compare_done)
                     state_q <= S_UPD;
               S_UPD:
               begin
                  refresh_q <= 1'b1; // RULE_09
                  if (halt_now)
                  begin
                     status_q[idx_q] <= `ST_HALT; // RULE_11
                     active_q <= 1'b0;
                     state_q <= S_IDLE;
                  end
                  else
                  begin
                     if (reached)
                     begin
                        status_q[idx_q] <= `ST_DONE; // RULE_07
                        fin_q[idx_q] <= 1'b1;
                     end
                     else
                        status_q[idx_q] <= pass_now ? `ST_PASS : `ST_FAIL; // RULE_10
                     state_q <= S_NEXT; // RULE_06
                  end
               end
               S_NEXT:
                  if (!any_left)
                  begin
                     active_q <= 1'b0; // RULE_17
                     refresh_q <= 1'b1;
                     state_q <= S_IDLE;
                  end
                  else
                  begin
                     // wraps past the end file, skipping finished tests
                     idx_q <= nxt; // RULE_17
                     setup_slot_q <= base_q + {1'b0, nxt};
                     cur_test_q <= base_q + {1'b0, nxt}; // RULE_08
                     setup_rd_q <= 1'b1; // RULE_05
                     state_q <= S_SETUP;
                  end
               default:
                  state_q <= S_IDLE;
            endcase
      end
endmodule // compare_autosequencer

// ---- testbench/autoseq_sva.sv ----
`timescale 1ns/10ps
module autoseq_sva (
   // clock and reset
   input wire clk,
   input wire rst,
   // commands
   input wire begin_sequence_key,
   input wire abort_key,
   // handshakes
   input wire setup_rd_q,
   input wire setup_valid,
   input wire [15:0] setup_passes,
   input wire ref_load_q,
   input wire ref_done,
   input wire capture_q,
   input wire capture_done,
   input wire compare_q,
   input wire compare_done,
   // results
   input wire active_q,
   input wire view_q,
   input wire refresh_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // abort wins, so the update is only owed when no abort lands
   sequence s_cmp;
      compare_done && active_q && !abort_key ##1 !abort_key;
   endsequence
   property p_beg;
      begin_sequence_key && !active_q && !abort_key |=> setup_rd_q && active_q && view_q;
   endproperty
   property p_ref;
      setup_valid && active_q && !abort_key && setup_passes != 16'h0000 |=> ref_load_q;
   endproperty
   // a zero pass goal is finished without touching the reference
   property p_zero;
      setup_valid && active_q && !abort_key && setup_passes == 16'h0000 |=> !ref_load_q;
   endproperty
   property p_cap;
      ref_done && active_q && !abort_key |=> capture_q;
   endproperty
   property p_cmp;
      capture_done && active_q && !abort_key |=> compare_q;
   endproperty
   property p_upd;
      s_cmp |=> refresh_q;
   endproperty
   property p_abt;
      abort_key && active_q |=> !active_q;
   endproperty
   property p_one;
      $onehot0({setup_rd_q, ref_load_q, capture_q, compare_q});
   endproperty
   property p_idle;
      !active_q && !begin_sequence_key |=> !active_q && !setup_rd_q;
   endproperty
   property p_view;
      active_q |-> view_q;
   endproperty
   a_beg: assert property (p_beg) else $error("start not taken");
   a_ref: assert property (p_ref) else $error("no reference load");
   a_zero: assert property (p_zero) else $error("zero goal still loaded");
   a_cap: assert property (p_cap) else $error("no capture");
   a_cmp: assert property (p_cmp) else $error("no compare");
   a_upd: assert property (p_upd) else $error("no results update");
   a_abt: assert property (p_abt) else $error("abort ignored");
   a_one: assert property (p_one) else $error("steps overlap");
   a_idle: assert property (p_idle) else $error("idle not quiet");
   a_view: assert property (p_view) else $error("results view off");
endmodule // autoseq_sva
bind compare_autosequencer autoseq_sva i_sva (.*);

// ---- testbench/far_side_model.sv ----
`timescale 1ns/10ps
module far_side_model (
   // clock and pace
   input  wire        clk,
   input  wire        slow,
   // requests
   input  wire        setup_rd_q,
   input  wire [3:0]  setup_slot_q,
   input  wire        ref_load_q,
   input  wire        capture_q,
   input  wire        compare_q,
   // answers
   output wire        setup_valid,
   output wire [3:0]  setup_ref_file,
   output wire [15:0] setup_passes,
   output wire [15:0] setup_a_start,
   output wire        setup_cond,
   output wire        setup_cont_mode,
   output wire        setup_pass_cond,
   output wire        ref_done,
   output wire        capture_done,
   output wire        compare_done,
   output wire [15:0] compare_hits
);
   // setups held in consecutive slots, cfg is mode, cond, pass cond
   reg [15:0] pas [0:15];
   reg [15:0] hit [0:15];
   reg [15:0] a_s [0:15];
   reg [2:0]  cfg [0:15];
   reg [3:0]  slot_q, d1, d2, d3;
   reg        hv_q;
   reg [15:0] junk_q = 16'h0000;
   always @(posedge clk)
   begin
      d1 <= {setup_rd_q, ref_load_q, capture_q, compare_q};
      d2 <= d1;
      d3 <= d2;
      hv_q <= compare_done;
      junk_q <= {junk_q[14:0], ~junk_q[15]};
      if (setup_rd_q) slot_q <= setup_slot_q;
   end
   assign {setup_valid, ref_done, capture_done, compare_done} = slow ? d3 : d1;
   // outside the valid cycle the lines churn so stale data cannot pass
   assign setup_passes = setup_valid ? pas[slot_q] : junk_q;
   assign setup_a_start = setup_valid ? a_s[slot_q] : ~junk_q;
   assign setup_ref_file = setup_valid ? slot_q ^ 4'h9 : junk_q[3:0];
   assign {setup_cont_mode, setup_cond, setup_pass_cond} = setup_valid ? cfg[slot_q] : junk_q[2:0];
   assign compare_hits = hv_q ? hit[slot_q] : junk_q;
endmodule // far_side_model

// ---- testbench/compare_autosequencer_tb.sv ----
`timescale 1ns/10ps
module compare_autosequencer_tb;
   reg clk, rst, begin_sequence_key, abort_key, slow;
   reg [3:0] start_file, end_file;
   wire setup_rd_q, ref_load_q, capture_q, compare_q, cmp_word_mode_q, cmp_cond_q, active_q, view_q, refresh_q;
   wire setup_valid, ref_done, capture_done, compare_done, setup_cond, setup_cont_mode, setup_pass_cond;
   wire [3:0] setup_slot_q, ref_file_q, cmp_skew_q, cur_test_q, setup_ref_file;
   wire [15:0] cmp_a_start_q, cmp_b_start_q, cmp_b_end_q, compare_hits, setup_passes, setup_a_start;
   wire [23:0] status_flat;
   wire [127:0] pass_flat, fail_flat, att_flat;
   wire [15:0] setup_b_start = 16'h0000;
   wire [15:0] setup_b_end = 16'h0100;
   wire setup_word_mode = 1'b1;
   wire [3:0] setup_skew = 4'h2;
   integer fails = 0, checks_done = 0, seed = 32'h0000_fcb4, i;
   reg [20:0] q [$];
   reg [20:0] it;
   compare_autosequencer i_dut (.*);
   far_side_model i_far (.*);
   initial begin clk = 1'b0; forever #10 clk = ~clk; end
   ////////////////////////////////////////////////////////////
   task chk(input string nm, input [15:0] e, input [15:0] g);
      checks_done = checks_done + 1;
      if (e !== g)
      begin
         $display("[ERR] %s exp %h got %h", nm, e, g);
         fails = fails + 1;
      end
   endtask
   task end_of_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cf(input [3:0] s, input [15:0] p, input [15:0] h, input [2:0] c);
      i_far.pas[s] = p;
      i_far.hit[s] = h;
      i_far.cfg[s] = c;
      i_far.a_s[s] = $random(seed);
   endtask
   task push(input [3:0] s);
      q.push_back({s, i_far.cfg[s][1], i_far.a_s[s]});
   endtask
   task go(input [3:0] s, input [3:0] e);
      @(negedge clk);
      start_file = s;
      end_file = e;
      begin_sequence_key = 1'b1;
      @(negedge clk);
      begin_sequence_key = 1'b0;
   endtask
   task wait_idle;
      i = 0;
      while (active_q !== 1'b0 && i < 3000) begin @(negedge clk); i = i + 1; end
      chk("busy", 0, active_q);
      chk("left", 0, q.size());
   endtask
   task fin(input integer t, input [2:0] s, input [15:0] p, input [15:0] f, input [15:0] a);
      chk("status", s, status_flat[3*t +: 3]);
      chk("pass", p, pass_flat[16*t +: 16]);
      chk("fail", f, fail_flat[16*t +: 16]);
      chk("att", a, att_flat[16*t +: 16]);
   endtask
   ////////////////////////////////////////////////////////////
   // each compare request must belong to the next expected test
   always @(posedge clk)
      if (compare_q === 1'b1)
      begin
         if (q.size() == 0) chk("extra compare", 0, 1);
         else
         begin
            it = q.pop_front();
            chk("test", it[20:17], cur_test_q);
            chk("cond", it[16], cmp_cond_q);
            chk("a_start", it[15:0], cmp_a_start_q);
            chk("ref", it[20:17] ^ 4'h9, ref_file_q);
            chk("slot", it[20:17], setup_slot_q);
            chk("b_start", 16'h0000, cmp_b_start_q);
            chk("b_end", 16'h0100, cmp_b_end_q);
            chk("skew", 4'h2, cmp_skew_q);
            chk("word", 1'b1, cmp_word_mode_q);
         end
      end
   initial begin #400000; fails = fails + 1; end_of_test; end
   initial
   begin
      rst = 1'b1;
      {begin_sequence_key, abort_key, slow} = 3'h0;
      start_file = 4'h0;
      end_file = 4'h0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      // count-if range with a zero-pass test in the middle
      cf(4, 16'h0002, 16'h0003, 3'h7);
      cf(5, 16'h0000, 16'h0001, 3'h7);
      cf(6, 16'h0001, 16'h0000, 3'h4);
      push(4); push(6); push(4);
      go(4, 6);
      go(0, 7); // ignored while running
      wait_idle;
      fin(0, 3'h4, 16'h0002, 16'h0000, 16'h0002);
      fin(1, 3'h4, 16'h0000, 16'h0000, 16'h0000);
      fin(2, 3'h4, 16'h0000, 16'h0001, 16'h0001);
      $display("count-if sequence done");
      // halt-if: no hits passes on, hits halt the run
      slow = 1'b1;
      cf(2, 16'h0001, 16'h0000, 3'h2);
      cf(3, 16'h0003, 16'h0005, 3'h3);
      push(2); push(3);
      go(2, 3);
      wait_idle;
      fin(0, 3'h4, 16'h0001, 16'h0000, 16'h0001);
      chk("halt", 3'h5, status_flat[5:3]);
      chk("att halt", 16'h0001, att_flat[31:16]);
      chk("cleared", 16'h0000, att_flat[47:32]);
      $display("halt-if sequence done");
      // eight tests, abort before the first result lands
      slow = 1'b0;
      for (i = 0; i < 8; i = i + 1) cf(i, 16'h0064, $random(seed), 3'h4);
      push(0);
      go(0, 7);
      i = 0;
      while (compare_q !== 1'b1 && i < 100) begin @(negedge clk); i = i + 1; end
      chk("cmp seen", 1, compare_q);
      abort_key = 1'b1;
      @(negedge clk);
      abort_key = 1'b0;
      chk("active", 0, active_q);
      repeat (5) @(negedge clk);
      fin(0, 3'h1, 16'h0000, 16'h0000, 16'h0000);
      $display("abort sequence done");
      end_of_test;
   end
endmodule // compare_autosequencer_tb
